// >>> shared/fcfc_defs.vh
// Purpose: Constants of the fully closed feedback counter.
// Assumes: Included by bare name from the design files.
// Notes: Byte offsets on the APB register bus, reset values and field positions.
`ifndef FCFC_DEFS_VH
`define FCFC_DEFS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define FCFC_A_TYPE 8'h00
`define FCFC_A_NUM 8'h04
`define FCFC_A_DEN 8'h08
`define FCFC_A_DIR 8'h0C
`define FCFC_A_ZCHK 8'h10
`define FCFC_A_OVF 8'h14
`define FCFC_A_CLR 8'h18
`define FCFC_A_MROT 8'h1C
`define FCFC_A_MAXSPD 8'h20
`define FCFC_A_CTRL 8'h24
`define FCFC_A_STAT 8'h28
`define FCFC_A_MASK 8'h2C
`define FCFC_A_ERR 8'h30
`define FCFC_A_EXTMON 8'h34

// ----------------------------------------------------------------------
// Field widths and reset values
// ----------------------------------------------------------------------
`define FCFC_W_TYPE 2
`define FCFC_W_NUM 21
`define FCFC_W_OVF 28
`define FCFC_W_CLR 7
`define FCFC_W_SPD 16
`define FCFC_W_STAT 3
`define FCFC_R_TYPE 2'h0
`define FCFC_R_NUM 21'h000000
`define FCFC_R_DEN 21'h002710
`define FCFC_R_OVF 28'h0003E80
`define FCFC_R_CLR 7'h00
`define FCFC_R_MAXSPD 16'hFFFF

// ----------------------------------------------------------------------
// Encodings and field positions
// ----------------------------------------------------------------------
`define FCFC_T_QUAD 2'h0
`define FCFC_T_SER 2'h1
`define FCFC_S_DEV 0
`define FCFC_S_ACC 1
`define FCFC_S_ZLOSS 2
`define FCFC_C_REINIT 0

`endif

// >>> src/fcfc_edge_decoder.v
// Purpose: Turns external encoder pins into count-up, count-down and index pulses.
// Assumes: All pins are asynchronous to i_clk.
// Notes: Quadrature decoding is by four; serial type gives one count per rising step edge.
`timescale 1ns/100ps
`include "fcfc_defs.vh"

module fcfc_edge_decoder (
  input wire i_clk,
  input wire i_arst_n,
  input wire [1:0] i_type,
  input wire i_pha,
  input wire i_phb,
  input wire i_phz,
  input wire i_ser_step,
  input wire i_ser_dir,
  output reg o_up,
  output reg o_down,
  output reg o_zedge
);

  // ----------------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------------
  reg [4:0] meta_q;
  reg [4:0] sync_q;
  reg [4:0] prev_q;
  wire a = sync_q[0];
  wire b = sync_q[1];
  wire mv = (a ^ prev_q[0]) ^ (b ^ prev_q[1]);
  wire step = sync_q[3] & ~prev_q[3];

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= 5'h00;
      sync_q <= 5'h00;
      prev_q <= 5'h00;
      o_up <= 1'b0;
      o_down <= 1'b0;
      o_zedge <= 1'b0;
    end else begin
      meta_q <= {i_ser_dir, i_ser_step, i_phz, i_phb, i_pha};
      sync_q <= meta_q;
      prev_q <= sync_q;
      o_zedge <= sync_q[2] & ~prev_q[2];
      if (i_type == `FCFC_T_QUAD) begin
        // Phase A leading phase B counts up.
        o_up <= mv & (a ^ prev_q[1]);
        o_down <= mv & ~(a ^ prev_q[1]);
      end else if (i_type == `FCFC_T_SER) begin
        o_up <= step & ~sync_q[4];
        o_down <= step & sync_q[4];
      end else begin
        // The reserved codes 2 and 3 count nothing.
        o_up <= 1'b0;
        o_down <= 1'b0;
      end
    end
  end

endmodule // fcfc_edge_decoder

// >>> src/fcfc_top.v
// Purpose: Fully closed loop feedback counter with APB registers.
// Assumes: Motor encoder steps come from logic on i_clk; encoder pins are asynchronous.
// Notes: Settings other than speed limit and mask take effect on a re-initialisation command, standing in for a power cycle.
//
// Behaviour
// - Type 0 selects the quadrature input and type 1 the serial incremental input.
// - With no reversal, the external count rises for counterclockwise and falls for clockwise.
// - Direction switch 0 counts pulses as they come and 1 inverts the count direction.
// - Rotation direction setting 1 makes the monitored total count opposite to the count.
// - A speed command above the motor maximum raises an acceleration error.
// - External counts enter the position error scaled by numerator over denominator, defaults 0 and 10000.
// - A numerator of 0 uses the motor encoder resolution per rotation instead.
// - For quadrature input, index loss detection runs when its setting is 0, not when 1.
// - The motor minus external position error is kept and overflow beyond the level errors.
// - The position error clears each time the motor completes the set rotation count.
`timescale 1ns/100ps
`include "fcfc_defs.vh"

module fcfc_top #(
  parameter [20:0] MOT_RES = 21'h020000,
  parameter [20:0] ZLOSS_PULSES = 21'h010000
) (
  input wire i_clk,
  input wire i_arst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg o_pready,
  output reg [31:0] o_prdata,
  output reg o_pslverr,
  input wire i_pha,
  input wire i_phb,
  input wire i_phz,
  input wire i_ser_step,
  input wire i_ser_dir,
  input wire i_mot_step,
  input wire i_mot_dir,
  input wire [15:0] i_speed_cmd,
  output reg o_irq
);

  // ----------------------------------------------------------------------
  // Written settings and settings in use
  // ----------------------------------------------------------------------
  reg [1:0] type_q;
  reg [20:0] num_q;
  reg [20:0] den_q;
  reg dir_q;
  reg zchk_q;
  reg [27:0] ovf_q;
  reg [6:0] clr_q;
  reg mrot_q;
  reg [15:0] maxspd_q;
  reg [2:0] stat_q;
  reg [2:0] mask_q;
  reg [1:0] a_type_q;
  reg [20:0] a_num_q;
  reg [20:0] a_den_q;
  reg a_dir_q;
  reg a_zchk_q;
  reg [27:0] a_ovf_q;
  reg [6:0] a_clr_q;
  reg a_mrot_q;
  reg reinit_q;

  // ----------------------------------------------------------------------
  // Counting state
  // ----------------------------------------------------------------------
  reg signed [31:0] err_q;
  reg signed [31:0] err_d;
  reg signed [31:0] rem_q;
  reg signed [31:0] rem_d;
  reg signed [31:0] extmon_q;
  reg [20:0] step_q;
  reg [6:0] rot_q;
  reg [20:0] zcnt_q;
  reg conv_up;
  reg conv_dn;
  reg [2:0] ev;
  reg clr_now;

  wire ext_up;
  wire ext_dn;
  wire zedge;
  wire cnt_up = a_dir_q ? ext_dn : ext_up;
  wire cnt_dn = a_dir_q ? ext_up : ext_dn;
  wire [20:0] eff_num = (a_num_q == `FCFC_R_NUM) ? MOT_RES : a_num_q;
  wire signed [31:0] num_s = {11'h000, eff_num};
  wire signed [31:0] den_s = {11'h000, a_den_q};
  wire signed [31:0] ovf_s = {4'h0, a_ovf_q};
  wire psel_acc = i_psel & i_penable;
  wire acc = psel_acc & o_pready;
  wire wr = acc & i_pwrite;

  fcfc_edge_decoder u_dec (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_type(a_type_q),
    .i_pha(i_pha),
    .i_phb(i_phb),
    .i_phz(i_phz),
    .i_ser_step(i_ser_step),
    .i_ser_dir(i_ser_dir),
    .o_up(ext_up),
    .o_down(ext_dn),
    .o_zedge(zedge)
  );

  // ----------------------------------------------------------------------
  // Scaling and error arithmetic
  // ----------------------------------------------------------------------
  // The remainder drains one motor unit per cycle, so a burst of external
  // pulses with a large ratio is spread over later cycles instead of lost.
  always @* begin
    rem_d = rem_q;
    if (cnt_up) begin
      rem_d = rem_q + num_s;
    end else if (cnt_dn) begin
      rem_d = rem_q - num_s;
    end
    conv_up = 1'b0;
    conv_dn = 1'b0;
    if (rem_d >= den_s) begin
      rem_d = rem_d - den_s;
      conv_up = 1'b1;
    end else if (rem_d <= -den_s) begin
      rem_d = rem_d + den_s;
      conv_dn = 1'b1;
    end
  end

  always @* begin
    clr_now = 1'b0;
    if (a_clr_q != `FCFC_R_CLR && rot_q == a_clr_q) begin
      clr_now = 1'b1;
    end
    err_d = err_q;
    if (i_mot_step) begin
      err_d = i_mot_dir ? err_d - 32'sd1 : err_d + 32'sd1;
    end
    if (conv_up) begin
      err_d = err_d - 32'sd1;
    end else if (conv_dn) begin
      err_d = err_d + 32'sd1;
    end
    if (clr_now) begin
      err_d = 32'sd0;
    end
  end

  // ----------------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------------
  always @* begin
    ev = 3'h0;
    ev[`FCFC_S_DEV] = (err_q > ovf_s) || (err_q < -ovf_s);
    ev[`FCFC_S_ACC] = (i_speed_cmd > maxspd_q);
    ev[`FCFC_S_ZLOSS] = (a_type_q == `FCFC_T_QUAD) && !a_zchk_q
      && (zcnt_q >= ZLOSS_PULSES);
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      err_q <= 32'sd0;
      rem_q <= 32'sd0;
      extmon_q <= 32'sd0;
      step_q <= 21'h000000;
      rot_q <= 7'h00;
      zcnt_q <= 21'h000000;
    end else if (reinit_q) begin
      err_q <= 32'sd0;
      rem_q <= 32'sd0;
      extmon_q <= 32'sd0;
      step_q <= 21'h000000;
      rot_q <= 7'h00;
      zcnt_q <= 21'h000000;
    end else begin
      err_q <= err_d;
      rem_q <= rem_d;
      // The monitored total runs against the count when set to 1.
      if (cnt_up ^ a_mrot_q & (cnt_up | cnt_dn)) begin
        extmon_q <= extmon_q + 32'sd1;
      end else if (cnt_up | cnt_dn) begin
        extmon_q <= extmon_q - 32'sd1;
      end
      if (clr_now) begin
        rot_q <= 7'h00;
      end else if (i_mot_step && step_q == MOT_RES - 21'h000001) begin
        rot_q <= rot_q + 7'h01;
      end
      if (i_mot_step) begin
        step_q <= (step_q == MOT_RES - 21'h000001) ? 21'h000000 : step_q + 21'h000001;
      end
      if (zedge) begin
        zcnt_q <= 21'h000000;
      end else if ((ext_up | ext_dn) && zcnt_q != ZLOSS_PULSES) begin
        zcnt_q <= zcnt_q + 21'h000001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------------
  reg mapped;
  reg [31:0] rd;

  always @* begin
    mapped = 1'b1;
    rd = 32'h00000000;
    case (i_paddr)
      `FCFC_A_TYPE: rd[1:0] = type_q;
      `FCFC_A_NUM: rd[20:0] = num_q;
      `FCFC_A_DEN: rd[20:0] = den_q;
      `FCFC_A_DIR: rd[0] = dir_q;
      `FCFC_A_ZCHK: rd[0] = zchk_q;
      `FCFC_A_OVF: rd[27:0] = ovf_q;
      `FCFC_A_CLR: rd[6:0] = clr_q;
      `FCFC_A_MROT: rd[0] = mrot_q;
      `FCFC_A_MAXSPD: rd[15:0] = maxspd_q;
      `FCFC_A_CTRL: rd = 32'h00000000;
      `FCFC_A_STAT: rd[2:0] = stat_q;
      `FCFC_A_MASK: rd[2:0] = mask_q;
      `FCFC_A_ERR: rd = err_q;
      `FCFC_A_EXTMON: rd = extmon_q;
      default: mapped = 1'b0;
    endcase
  end

  // Every access takes one wait state, so pready comes from a flop.
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h00000000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= psel_acc & ~o_pready;
      if (psel_acc & ~o_pready) begin
        o_prdata <= i_pwrite ? 32'h00000000 : rd;
        o_pslverr <= ~mapped;
      end else begin
        o_prdata <= 32'h00000000;
        o_pslverr <= 1'b0;
      end
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      type_q <= `FCFC_R_TYPE;
      num_q <= `FCFC_R_NUM;
      den_q <= `FCFC_R_DEN;
      dir_q <= 1'b0;
      zchk_q <= 1'b0;
      ovf_q <= `FCFC_R_OVF;
      clr_q <= `FCFC_R_CLR;
      mrot_q <= 1'b0;
      maxspd_q <= `FCFC_R_MAXSPD;
      mask_q <= 3'h0;
      reinit_q <= 1'b0;
    end else begin
      reinit_q <= wr && i_paddr == `FCFC_A_CTRL && i_pwdata[`FCFC_C_REINIT];
      if (wr) begin
        case (i_paddr)
          `FCFC_A_TYPE: type_q <= i_pwdata[1:0];
          `FCFC_A_NUM: num_q <= i_pwdata[20:0];
          `FCFC_A_DEN: den_q <= i_pwdata[20:0];
          `FCFC_A_DIR: dir_q <= i_pwdata[0];
          `FCFC_A_ZCHK: zchk_q <= i_pwdata[0];
          `FCFC_A_OVF: ovf_q <= i_pwdata[27:0];
          `FCFC_A_CLR: clr_q <= i_pwdata[6:0];
          `FCFC_A_MROT: mrot_q <= i_pwdata[0];
          `FCFC_A_MAXSPD: maxspd_q <= i_pwdata[15:0];
          `FCFC_A_MASK: mask_q <= i_pwdata[2:0];
          default: mask_q <= mask_q;
        endcase
      end
    end
  end

  // Settings in use change only on re-initialisation.
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      a_type_q <= `FCFC_R_TYPE;
      a_num_q <= `FCFC_R_NUM;
      a_den_q <= `FCFC_R_DEN;
      a_dir_q <= 1'b0;
      a_zchk_q <= 1'b0;
      a_ovf_q <= `FCFC_R_OVF;
      a_clr_q <= `FCFC_R_CLR;
      a_mrot_q <= 1'b0;
    end else if (reinit_q) begin
      a_type_q <= type_q;
      a_num_q <= num_q;
      a_den_q <= (den_q == 21'h000000) ? `FCFC_R_DEN : den_q;
      a_dir_q <= dir_q;
      a_zchk_q <= zchk_q;
      a_ovf_q <= (ovf_q == 28'h0000000) ? `FCFC_R_OVF : ovf_q;
      a_clr_q <= clr_q;
      a_mrot_q <= mrot_q;
    end
  end

  // ----------------------------------------------------------------------
  // Sticky status and interrupt
  // ----------------------------------------------------------------------
  // A new event in the clearing cycle wins over the write of one.
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stat_q <= 3'h0;
      o_irq <= 1'b0;
    end else begin
      if (wr && i_paddr == `FCFC_A_STAT) begin
        stat_q <= (stat_q & ~i_pwdata[2:0]) | ev;
      end else begin
        stat_q <= stat_q | ev;
      end
      o_irq <= |(stat_q & mask_q);
    end
  end

endmodule // fcfc_top

// >>> testbench/fcfc_enc_model.sv
// Purpose: Behavioural load-side encoder, quadrature or serial step type.
// Assumes: Steps are launched just after a rising edge of i_clk.
// Notes: Gaps under three cycles are never asked for, the design may drop them.
`timescale 1ns/100ps
module fcfc_enc_model (
  input wire i_clk,
  output reg o_pha,
  output reg o_phb,
  output reg o_phz,
  output reg o_ser_step,
  output reg o_ser_dir
);
  reg [1:0] pos_q = 2'h0;
  initial begin
    o_pha = 1'b0;
    o_phb = 1'b0;
    o_phz = 1'b0;
    o_ser_step = 1'b0;
    o_ser_dir = 1'b0;
  end
  // Counterclockwise turns put A ahead of B, the expected wiring.
  task automatic steps(input ccw, input ser, input zen, input integer k, input integer gap);
    integer i;
    begin
      for (i = 0; i < k; i = i + 1) begin
        @(posedge i_clk);
        if (ser) begin
          o_ser_dir <= !ccw;
          o_ser_step <= 1'b1;
        end else begin
          pos_q = ccw ? pos_q + 2'h1 : pos_q - 2'h1;
          o_pha <= pos_q[0] ^ pos_q[1];
          o_phb <= pos_q[1];
          o_phz <= zen && pos_q == 2'h0;
        end
        repeat (gap) @(posedge i_clk);
        // A released direction line shows the opposite level, never a held one.
        o_ser_step <= 1'b0;
        o_ser_dir <= ccw;
        repeat (gap) @(posedge i_clk);
      end
    end
  endtask
endmodule // fcfc_enc_model

// >>> testbench/fcfc_top_properties.sv
// Purpose: Port-level assertions of the fully closed feedback counter.
// Assumes: APB masters hold every request until pready is high.
// Notes: Speed limit and mask are shadowed from completed bus writes.
`timescale 1ns/100ps
`include "fcfc_defs.vh"
module fcfc_top_properties (
  input wire i_clk,
  input wire i_arst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [15:0] i_speed_cmd,
  input wire o_pready,
  input wire [31:0] o_prdata,
  input wire o_pslverr,
  input wire o_irq
);
  // ----------------------------------------------------------------------
  // Shadow registers
  // ----------------------------------------------------------------------
  reg [15:0] maxspd_q;
  reg [2:0] mask_q;
  wire wr_done = i_psel && i_penable && o_pready && i_pwrite;
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      maxspd_q <= `FCFC_R_MAXSPD;
      mask_q <= 3'h0;
    end else if (wr_done) begin
      if (i_paddr == `FCFC_A_MAXSPD) maxspd_q <= i_pwdata[15:0];
      if (i_paddr == `FCFC_A_MASK) mask_q <= i_pwdata[2:0];
    end
  end
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  sequence s_access;
    i_psel && !i_penable ##1 i_psel && i_penable;
  endsequence
  sequence s_masked;
    (mask_q == 3'h0) [*3];
  endsequence
  access_answer_a: assert property (s_access |=> o_pready)
    else $error("pready missing after access");
  pready_single_a: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  pready_access_a: assert property (o_pready |-> i_psel && i_penable)
    else $error("pready outside access phase");
  rdata_idle_a: assert property (!o_pready |-> o_prdata == 32'h00000000)
    else $error("read data outside answer");
  slverr_map_a: assert property (o_pready && i_paddr[1:0] == 2'h0
    |-> o_pslverr == (i_paddr > `FCFC_A_EXTMON)) else $error("slave error wrong");
  type_width_a: assert property (o_pready && !i_pwrite && i_paddr == `FCFC_A_TYPE
    |-> o_prdata[31:2] == 30'h0) else $error("type field too wide");
  accel_irq_a: assert property (i_speed_cmd > maxspd_q && mask_q[1]
    |-> ##[1:3] o_irq) else $error("acceleration interrupt missing");
  masked_quiet_a: assert property (s_masked |-> !o_irq)
    else $error("interrupt while fully masked");
endmodule // fcfc_top_properties

bind fcfc_top fcfc_top_properties u_fcfc_top_properties (.i_clk(i_clk), .i_arst_n(i_arst_n),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .i_speed_cmd(i_speed_cmd), .o_pready(o_pready), .o_prdata(o_prdata),
  .o_pslverr(o_pslverr), .o_irq(o_irq));

// >>> testbench/fcfc_top_tb.sv
// Purpose: Self-checking bench of the fully closed feedback counter.
// Assumes: Motor steps and speed come from here, load pins from the model.
// Notes: Small rotation and index counts keep the run short.
`timescale 1ns/100ps
`include "fcfc_defs.vh"
module fcfc_top_tb;
  reg i_clk = 1'b0;
  reg i_arst_n = 1'b0;
  reg psel = 1'b0;
  reg pen = 1'b0;
  reg pwr = 1'b0;
  reg mstep = 1'b0;
  reg mdir = 1'b0;
  reg [7:0] pa = 8'h00;
  reg [31:0] pwd = 32'h00000000;
  reg [15:0] spd = 16'h0000;
  reg [31:0] rd;
  wire rdy, serr, irq, pha, phb, phz, sst, sdr;
  wire [31:0] prd;
  integer miscompares = 0;
  integer n_tests = 0;
  always #10 i_clk = ~i_clk;
  fcfc_top #(.MOT_RES(21'h000004), .ZLOSS_PULSES(21'h000008)) u_fcfc_top (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(pa), .i_pwdata(pwd), .o_pready(rdy), .o_prdata(prd), .o_pslverr(serr),
    .i_pha(pha), .i_phb(phb), .i_phz(phz), .i_ser_step(sst), .i_ser_dir(sdr),
    .i_mot_step(mstep), .i_mot_dir(mdir), .i_speed_cmd(spd), .o_irq(irq));
  fcfc_enc_model u_fcfc_enc_model (.i_clk(i_clk), .o_pha(pha), .o_phb(phb), .o_phz(phz),
    .o_ser_step(sst), .o_ser_dir(sdr));
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge i_clk);
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge i_clk);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge i_clk);
      pen <= 1'b1;
      // Only the watchdog ends a wait, so a missing answer fails the run.
      @(posedge i_clk);
      while (rdy !== 1'b1) begin
        @(posedge i_clk);
      end
      rd = prd;
      psel <= 1'b0;
      pen <= 1'b0;
    end
  endtask
  task rchk(input [7:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(rd, e);
    end
  endtask
  task mot(input dir, input integer k);
    repeat (k) begin
      @(posedge i_clk);
      mdir <= dir;
      mstep <= 1'b1;
      @(posedge i_clk);
      mstep <= 1'b0;
    end
  endtask
  task enc(input ccw, input ser, input zen, input integer k, input integer gap);
    begin
      u_fcfc_enc_model.steps(ccw, ser, zen, k, gap);
      wt(20);
    end
  endtask
  // Software only ever writes type codes 0 and 1.
  task cfg(input [1:0] ty, input [20:0] nm, input [20:0] dn, input dv, input zc,
    input [27:0] ov, input [6:0] cl, input mr);
    begin
      apb(1'b1, `FCFC_A_TYPE, {30'h0, ty});
      apb(1'b1, `FCFC_A_NUM, {11'h0, nm});
      apb(1'b1, `FCFC_A_DEN, {11'h0, dn});
      apb(1'b1, `FCFC_A_DIR, {31'h0, dv});
      apb(1'b1, `FCFC_A_ZCHK, {31'h0, zc});
      apb(1'b1, `FCFC_A_OVF, {4'h0, ov});
      apb(1'b1, `FCFC_A_CLR, {25'h0, cl});
      apb(1'b1, `FCFC_A_MROT, {31'h0, mr});
      apb(1'b1, `FCFC_A_CTRL, 32'h1);
      apb(1'b1, `FCFC_A_STAT, 32'h7);
    end
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task t_reset;
    begin
      rchk(`FCFC_A_TYPE, 32'h0);
      rchk(`FCFC_A_NUM, 32'h0);
      rchk(`FCFC_A_DEN, 32'h2710);
      rchk(`FCFC_A_OVF, 32'h3E80);
      rchk(`FCFC_A_CLR, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      apb(1'b1, `FCFC_A_DIR, 32'h1);
      enc(1'b1, 1'b0, 1'b0, 4, 3);
      rchk(`FCFC_A_EXTMON, 32'h4);
    end
  endtask
  task t_type;
    begin
      cfg(2'h1, 21'h1, 21'h1, 1'b0, 1'b1, 28'h3E80, 7'h0, 1'b0);
      enc(1'b1, 1'b1, 1'b0, 4, 3);
      enc(1'b1, 1'b0, 1'b0, 4, 3);
      rchk(`FCFC_A_EXTMON, 32'h4);
      cfg(2'h0, 21'h1, 21'h1, 1'b0, 1'b1, 28'h3E80, 7'h0, 1'b0);
      enc(1'b1, 1'b1, 1'b0, 4, 6);
      rchk(`FCFC_A_EXTMON, 32'h0);
    end
  endtask
  task t_dir;
    integer i;
    reg [31:0] c;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        cfg(2'h0, 21'h1, 21'h1, i[0], 1'b1, 28'h3E80, 7'h0, i[1]);
        enc(1'b1, 1'b0, 1'b0, 4, 3);
        c = i[0] ? -32'h00000004 : 32'h00000004;
        rchk(`FCFC_A_EXTMON, i[1] ? -c : c);
        rchk(`FCFC_A_ERR, -c);
      end
    end
  endtask
  task t_ratio;
    begin
      cfg(2'h0, 21'h0, 21'h2, 1'b0, 1'b1, 28'h3E80, 7'h0, 1'b0);
      enc(1'b1, 1'b0, 1'b0, 4, 3);
      rchk(`FCFC_A_ERR, -32'h00000008);
      cfg(2'h0, 21'h3, 21'h2, 1'b0, 1'b1, 28'h3E80, 7'h0, 1'b0);
      enc(1'b1, 1'b0, 1'b0, 4, 3);
      rchk(`FCFC_A_ERR, -32'h00000006);
    end
  endtask
  task t_dev;
    begin
      cfg(2'h0, 21'h1, 21'h1, 1'b0, 1'b1, 28'h3, 7'h0, 1'b0);
      apb(1'b1, `FCFC_A_MASK, 32'h1);
      mot(1'b0, 3);
      wt(3);
      chk({31'h0, irq}, 32'h0);
      mot(1'b0, 1);
      wt(3);
      chk({31'h0, irq}, 32'h1);
      mot(1'b1, 4);
      apb(1'b1, `FCFC_A_STAT, 32'h7);
      rchk(`FCFC_A_STAT, 32'h0);
      apb(1'b1, `FCFC_A_MASK, 32'h0);
    end
  endtask
  task t_acc;
    begin
      apb(1'b1, `FCFC_A_MAXSPD, 32'h64);
      spd <= 16'h0064;
      apb(1'b1, `FCFC_A_STAT, 32'h7);
      rchk(`FCFC_A_STAT, 32'h0);
      spd <= 16'h0065;
      apb(1'b1, `FCFC_A_MASK, 32'h2);
      wt(3);
      chk({31'h0, irq}, 32'h1);
      rchk(`FCFC_A_STAT, 32'h2);
      spd <= 16'h0000;
      apb(1'b1, `FCFC_A_STAT, 32'h7);
      apb(1'b1, `FCFC_A_MASK, 32'h0);
    end
  endtask
  task t_clr;
    integer i;
    begin
      for (i = 0; i < 2; i = i + 1) begin
        cfg(2'h0, 21'h1, 21'h1, 1'b0, 1'b1, 28'h3E80, i ? 7'h0 : 7'h2, 1'b0);
        mot(1'b0, 4);
        wt(3);
        rchk(`FCFC_A_ERR, 32'h4);
        mot(1'b0, 4);
        wt(3);
        rchk(`FCFC_A_ERR, i ? 32'h8 : 32'h0);
      end
    end
  endtask
  task t_zloss;
    integer i;
    begin
      for (i = 0; i < 3; i = i + 1) begin
        cfg(2'h0, 21'h1, 21'h1, 1'b0, i[0], 28'h3E80, 7'h0, 1'b0);
        enc(1'b1, 1'b0, i[1], 12, 3);
        rchk(`FCFC_A_STAT, i == 0 ? 32'h4 : 32'h0);
      end
    end
  endtask
  // ----------------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------------
  task test_done;
    begin
      $display("tests=%0d miscompares=%0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    #1000000;
    miscompares = miscompares + 1;
    test_done;
  end
  initial begin
    wt(8);
    i_arst_n <= 1'b1;
    t_reset;
    t_type;
    t_dir;
    t_ratio;
    t_dev;
    t_acc;
    t_clr;
    t_zloss;
    test_done;
  end
endmodule // fcfc_top_tb
